// ===== fec_pkg.sv
// Purpose: Constants and types for the flash erase controller
// Assumes: 8-bit command bytes, 512-byte pages, 64 KB array
// Notes:   Timing counts derived from the 250 MHz core clock
// What this block does
// [RULE1] Programmer programs byte at most twice per erase
// [RULE2] Page erase sets one 512-byte page FFH
// [RULE3] Erased page taken from page-select at command
// [RULE4] Unlocked command 95H starts page erase
// [RULE5] Core idles during erase, clock keeps running
// [RULE6] Debugger polls status for page erase end
// [RULE7] Page erase completion relocks controller
// [RULE8] Unlocked command 63H starts whole-array erase
// [RULE9] Whole-array erase sets every byte FFH
// [RULE10] Debugger polls status for mass erase end
// [RULE11] Mass erase completion relocks controller
// [RULE12] Bypass routes raw flash controls to pins
// [RULE13] Bypass still allows page and mass erase; code refuses 95H and 63H commands in bypass, erase only via pin strobes
// [RULE14] Status busy from command until erase done
package fec_pkg;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
	localparam logic [7:0] ERASED_BYTE    = 8'hff;
	localparam int         PAGE_BYTES     = 512;
	localparam int         PAGE_BITS      = 7;
	localparam int         OFFS_BITS      = 9;
	localparam int         CLK_MHZ        = 250;
	localparam int         PAGE_ERASE_US  = 10;
	localparam int         MASS_ERASE_US  = 200;
	localparam int         PAGE_ERASE_CYC = PAGE_ERASE_US * CLK_MHZ;
	localparam int         MASS_ERASE_CYC = MASS_ERASE_US * CLK_MHZ;
	localparam int         CNT_BITS       = 16;
	localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
	localparam logic [1:0] STAT_IDLE      = 2'h0;
	localparam logic [1:0] STAT_PAGE      = 2'h1;
	localparam logic [1:0] STAT_MASS      = 2'h2;
	typedef enum logic [1:0] {
		FEC_IDLE,
		FEC_PAGE,
		FEC_MASS,
		FEC_DONE
	} fec_state_t;
endpackage

// ===== fec_timer.sv
// Purpose: Erase duration counter
// Assumes: Load pulse only when idle
// Notes:   Done is a one-cycle pulse when the count expires
`timescale 1ns/1ns
module fec_timer #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Control
	input  wire logic             load_in,
	input  wire logic [WIDTH-1:0] count_in,
	output logic                  done_out
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic             running;
	logic             next_running;
	logic             done;
	logic             next_done;

	always_comb begin
		next_count   = count;
		next_running = running;
		next_done    = 1'b0;
		if (load_in) begin
			next_count   = count_in;
			next_running = 1'b1;
		end else if (running) begin
			if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
				next_running = 1'b0;
				next_done    = 1'b1;
			end else begin
				next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			count   <= '0;
			running <= 1'b0;
			done    <= 1'b0;
		end else begin
			count   <= next_count;
			running <= next_running;
			done    <= next_done;
		end
	end

	assign done_out = done;
endmodule

// ===== fec_top.sv
// Purpose: Flash page and mass erase sequencer with bypass
// Assumes: Unlock logic lives outside; UNLOCKED_IN shows its state
// Notes:   Array erases by asserting page or mass strobes until done
`timescale 1ns/1ns
module fec_top #(
	parameter int PAGE_CYCLES = fec_pkg::PAGE_ERASE_CYC,
	parameter int MASS_CYCLES = fec_pkg::MASS_ERASE_CYC
) (
	// Clock and reset
	input  wire logic                           CORE_CLK_IN,
	input  wire logic                           RST_N_IN,
	// Control from processor or debugger
	input  wire logic                           UNLOCKED_IN,
	input  wire logic                           CMD_WR_IN,
	input  wire logic [7:0]                     CMD_DATA_IN,
	input  wire logic                           PAGE_WR_IN,
	input  wire logic [7:0]                     PAGE_DATA_IN,
	// Status
	output logic [7:0]                          PAGE_SEL_OUT,
	output logic [1:0]                          STATUS_OUT,
	output logic                                BUSY_OUT,
	output logic                                RELOCK_OUT,
	output logic                                CPU_IDLE_OUT,
	// Bypass
	input  wire logic                           BYPASS_IN,
	input  wire logic                           PIN_PAGE_ERASE_IN,
	input  wire logic                           PIN_MASS_ERASE_IN,
	input  wire logic [fec_pkg::PAGE_BITS-1:0]  PIN_PAGE_IN,
	// Flash array controls
	output logic                                ARR_PAGE_ERASE_OUT,
	output logic                                ARR_MASS_ERASE_OUT,
	output logic [fec_pkg::PAGE_BITS-1:0]       ARR_PAGE_OUT,
	output logic [7:0]                          ARR_FILL_OUT
);
	import fec_pkg::*;

	fec_state_t             state;
	fec_state_t             next_state;
	logic [7:0]             page_sel;
	logic [7:0]             next_page_sel;
	logic [PAGE_BITS-1:0]   erase_page;
	logic [PAGE_BITS-1:0]   next_erase_page;
	logic                   relock;
	logic                   next_relock;
	logic                   timer_load;
	logic [CNT_BITS-1:0]    timer_count;
	logic                   timer_done;

	function automatic logic is_cmd(input logic [7:0] data, input logic [7:0] code);
		is_cmd = (data == code);
	endfunction

	always_comb begin
		next_state      = state;
		next_page_sel   = page_sel;
		next_erase_page = erase_page;
		next_relock     = 1'b0;
		timer_load      = 1'b0;
		timer_count     = '0;
		if (PAGE_WR_IN && state == FEC_IDLE) begin
			next_page_sel = PAGE_DATA_IN;
		end
		case (state)
			FEC_IDLE: begin
				if (CMD_WR_IN && UNLOCKED_IN && !BYPASS_IN) begin
					if (is_cmd(CMD_DATA_IN, CMD_PAGE_ERASE)) begin // [RULE4]
						next_state      = FEC_PAGE;
						next_erase_page = page_sel[PAGE_BITS-1:0]; // [RULE3]
						timer_load      = 1'b1;
						timer_count     = CNT_BITS'(PAGE_CYCLES);
					end else if (is_cmd(CMD_DATA_IN, CMD_MASS_ERASE)) begin // [RULE8]
						next_state  = FEC_MASS;
						timer_load  = 1'b1;
						timer_count = CNT_BITS'(MASS_CYCLES);
					end
				end
			end
			FEC_PAGE, FEC_MASS: begin
				if (timer_done) begin
					next_state = FEC_DONE;
				end
			end
			FEC_DONE: begin
				next_relock = 1'b1; // [RULE7] [RULE11]
				next_state  = FEC_IDLE;
			end
			default: begin
				next_state = FEC_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			state      <= FEC_IDLE;
			page_sel   <= PAGE_SEL_RESET;
			erase_page <= '0;
			relock     <= 1'b0;
		end else begin
			state      <= next_state;
			page_sel   <= next_page_sel;
			erase_page <= next_erase_page;
			relock     <= next_relock;
		end
	end

	fec_timer #(
		.WIDTH(CNT_BITS)
	) u_timer (
		.clk_in  (CORE_CLK_IN),
		.rst_n_in(RST_N_IN),
		.load_in (timer_load),
		.count_in(timer_count),
		.done_out(timer_done)
	);

	// Internal erase or raw pin drive of the array
	always_comb begin
		if (BYPASS_IN && state == FEC_IDLE) begin
			ARR_PAGE_ERASE_OUT = PIN_PAGE_ERASE_IN; // [RULE12] [RULE13]
			ARR_MASS_ERASE_OUT = PIN_MASS_ERASE_IN; // [RULE13]
			ARR_PAGE_OUT       = PIN_PAGE_IN; // [RULE12]
		end else begin
			ARR_PAGE_ERASE_OUT = (state == FEC_PAGE); // [RULE2]
			ARR_MASS_ERASE_OUT = (state == FEC_MASS); // [RULE9]
			ARR_PAGE_OUT       = erase_page; // [RULE2]
		end
	end

	assign ARR_FILL_OUT = ERASED_BYTE; // [RULE2] [RULE9]
	assign PAGE_SEL_OUT = page_sel;
	assign BUSY_OUT     = (state == FEC_PAGE) || (state == FEC_MASS); // [RULE14]
	assign CPU_IDLE_OUT = BUSY_OUT; // [RULE5]
	assign RELOCK_OUT   = relock;
	assign STATUS_OUT   = (state == FEC_PAGE) ? STAT_PAGE :
	                      (state == FEC_MASS) ? STAT_MASS : STAT_IDLE; // [RULE14] [RULE6] [RULE10]
endmodule

// ===== fec_flash_model.sv
// Purpose: Flash array stand-in
// Assumes: Strobes are levels
// Notes:   Latches erased page and fill
`timescale 1ns/1ns
module fec_flash_model (
	input  wire logic       clk_in,
	input  wire logic       page_erase_in,
	input  wire logic       mass_erase_in,
	input  wire logic [6:0] page_in,
	input  wire logic [7:0] fill_in,
	output logic      [6:0] last_page_out,
	output logic      [7:0] byte_out
);
	always_ff @(posedge clk_in) begin
		if (page_erase_in || mass_erase_in) begin
			last_page_out <= page_in;
			byte_out      <= fill_in;
		end
	end
endmodule

// ===== fec_top_sva.sv
// Purpose: Port assertions
// Assumes: Short sim counts
// Notes:   Bound below
`timescale 1ns/1ns
module fec_top_sva #(parameter int PAGE_CYCLES = 8, parameter int MASS_CYCLES = 20) (
	input wire logic       CORE_CLK_IN, RST_N_IN, UNLOCKED_IN, CMD_WR_IN, BUSY_OUT, RELOCK_OUT,
	input wire logic       CPU_IDLE_OUT, BYPASS_IN, PIN_PAGE_ERASE_IN, ARR_PAGE_ERASE_OUT, ARR_MASS_ERASE_OUT,
	input wire logic [7:0] CMD_DATA_IN, PAGE_SEL_OUT, ARR_FILL_OUT,
	input wire logic [6:0] PIN_PAGE_IN, ARR_PAGE_OUT,
	input wire logic [1:0] STATUS_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic go;
	assign go = !BUSY_OUT && CMD_WR_IN && UNLOCKED_IN && !BYPASS_IN;
	start_page_a: assert property (go && !$past(BUSY_OUT) && CMD_DATA_IN == 8'h95
		|=> BUSY_OUT && STATUS_OUT == 2'h1 && ARR_PAGE_ERASE_OUT) else $error("page erase not started");
	start_mass_a: assert property (go && !$past(BUSY_OUT) && CMD_DATA_IN == 8'h63
		|=> BUSY_OUT && STATUS_OUT == 2'h2 && ARR_MASS_ERASE_OUT) else $error("mass erase not started");
	refuse_cmd_a: assert property (!BUSY_OUT && CMD_WR_IN && !(go && (CMD_DATA_IN == 8'h95 ||
		CMD_DATA_IN == 8'h63)) |=> !BUSY_OUT) else $error("refused command started erase");
	page_latch_a: assert property ($rose(ARR_PAGE_ERASE_OUT) && !BYPASS_IN |->
		ARR_PAGE_OUT == PAGE_SEL_OUT[6:0]) else $error("wrong page erased");
	core_stall_a: assert property (CPU_IDLE_OUT == BUSY_OUT) else $error("core stall mismatch");
	fill_value_a: assert property (ARR_FILL_OUT == 8'hff) else $error("fill not ff");
	auto_relock_a: assert property ($fell(BUSY_OUT) |-> ##[1:2] RELOCK_OUT) else $error("no relock");
	busy_span_a: assert property ($rose(BUSY_OUT) |-> BUSY_OUT[*8] ##[1:30] !BUSY_OUT)
		else $error("busy length wrong");
	status_busy_a: assert property ((STATUS_OUT != 2'h0) == BUSY_OUT) else $error("status mismatch");
	bypass_pins_a: assert property (BYPASS_IN && $past(BYPASS_IN) && !BUSY_OUT && $stable(PIN_PAGE_ERASE_IN)
		&& $stable(PIN_PAGE_IN) |-> ARR_PAGE_ERASE_OUT == PIN_PAGE_ERASE_IN && ARR_PAGE_OUT == PIN_PAGE_IN)
		else $error("bypass not routed");
	cover property ($rose(ARR_PAGE_ERASE_OUT));
	cover property ($rose(ARR_MASS_ERASE_OUT));
	cover property ($rose(RELOCK_OUT));
endmodule
bind fec_top fec_top_sva #(.PAGE_CYCLES(PAGE_CYCLES), .MASS_CYCLES(MASS_CYCLES)) i_sva (.*);

// ===== fec_top_tb.sv
// Purpose: Erase controller bench
// Assumes: Counts 8 and 20
// Notes:   Table rows then hand cases
`timescale 1ns/1ns
`define CHK(a,b) begin n_tests++; if ((a)!==(b)) begin mismatches++; $display("CHECK FAILED %0t %h %h",$time,a,b); end end
module fec_top_tb;
	logic       clk = 0, rst_n = 0, unl = 0, cw = 0, pw = 0, byp = 0, ppe = 0, pme = 0;
	logic [7:0] cd = 0, pd = 0, sel, fill, mb;
	logic [6:0] pp = 0, ap, lp;
	logic [1:0] st;
	logic       busy, rel, idle, ape, ame;
	int         mismatches = 0, n_tests = 0, k;
	logic [19:0] rows [6] = '{{2'h2, 8'h95, 8'h05, 2'h1}, {2'h2, 8'h63, 8'h7f, 2'h2}, {2'h0, 8'h95, 8'h01, 2'h0},
		{2'h3, 8'h63, 8'h02, 2'h0}, {2'h2, 8'h00, 8'h03, 2'h0}, {2'h2, 8'h96, 8'h04, 2'h0}};
	always #2 clk = ~clk;
	fec_top #(.PAGE_CYCLES(8), .MASS_CYCLES(20)) i_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .UNLOCKED_IN(unl),
		.CMD_WR_IN(cw), .CMD_DATA_IN(cd), .PAGE_WR_IN(pw), .PAGE_DATA_IN(pd), .PAGE_SEL_OUT(sel), .STATUS_OUT(st),
		.BUSY_OUT(busy), .RELOCK_OUT(rel), .CPU_IDLE_OUT(idle), .BYPASS_IN(byp), .PIN_PAGE_ERASE_IN(ppe),
		.PIN_MASS_ERASE_IN(pme), .PIN_PAGE_IN(pp), .ARR_PAGE_ERASE_OUT(ape), .ARR_MASS_ERASE_OUT(ame),
		.ARR_PAGE_OUT(ap), .ARR_FILL_OUT(fill));
	fec_flash_model i_flash (.clk_in(clk), .page_erase_in(ape), .mass_erase_in(ame), .page_in(ap), .fill_in(fill),
		.last_page_out(lp), .byte_out(mb));
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic poll();
		for (k = 0; k < 40 && busy !== 1'b0; k++) step(1);
		if (k == 40) begin
			mismatches++;
			report_and_stop();
		end
	endtask
	initial begin
		step(6);
		`CHK(sel, 8'h00)
		`CHK(st, 2'h0)
		rst_n = 1;
		foreach (rows[i]) begin
			pw = 1;
			pd = rows[i][9:2];
			step(1);
			pw = 0;
			`CHK(sel, rows[i][9:2])
			{unl, byp, cd} = rows[i][19:10];
			cw = 1;
			step(1);
			cw = 0;
			`CHK(st, rows[i][1:0])
			`CHK(idle, rows[i][1:0] != 2'h0)
			poll();
			if (rows[i][1:0] != 2'h0) begin
				step(1);
				`CHK(rel, 1'b1)
				`CHK(mb, 8'hff)
				if (rows[i][1:0] == 2'h1) `CHK(lp, rows[i][8:2])
			end else begin
				`CHK(rel, 1'b0)
			end
			unl = 0;
			byp = 0;
			step(2);
		end
		{pw, pd, unl, cw, cd} = {1'b1, 8'h03, 1'b1, 1'b0, 8'h95};
		step(1);
		{pw, cw} = 2'h1;
		step(1);
		{pw, cw, pd} = {2'h2, 8'h7a};
		step(1);
		{pw, cw, cd} = {2'h1, 8'h63};
		step(1);
		cw = 0;
		`CHK(sel, 8'h03)
		`CHK(st, 2'h1)
		rst_n = 0;
		step(6);
		`CHK(busy, 1'b0)
		{rst_n, unl, byp, ppe, pp} = {4'hb, 7'h11};
		step(2);
		`CHK(ap, 7'h11)
		`CHK(ape, 1'b1)
		`CHK(busy, 1'b0)
		{ppe, pme} = 2'h1;
		step(2);
		`CHK(ame, 1'b1)
		`CHK(ape, 1'b0)
		{byp, pme} = 2'h0;
		step(2);
		report_and_stop();
	end
endmodule
